// ==== hdl/ajc_pkg.sv ====
// constants, modes and carriers for the access, jitter and equalizer control bank
package ajc_pkg;

   // ------------------------------------------------------------
   // register map (index = printed offset, byte address = 4 * index)
   // ------------------------------------------------------------
   localparam int         ADDR_W         = 10;
   localparam logic [7:0] IDX_ACCESS     = 8'h13;
   localparam logic [7:0] IDX_JITTER     = 8'h18;
   localparam logic [7:0] IDX_EQUAL      = 8'h19;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h20;
   localparam logic [7:0] IDX_IRQ_MASK   = 8'h21;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int ACC_ALARM_SEL = 2;
   localparam int ACC_SEQ       = 1;
   localparam int ACC_FP_FMT    = 0;
   localparam int JA_ENABLE     = 7;
   localparam int JA_SIDE       = 6;
   localparam int JA_CENTRE     = 5;
   localparam int JA_DEPTH_LO   = 2;
   localparam int JA_CLEAR      = 1;
   localparam int EQ_DISABLE    = 7;
   localparam int EQ_MID        = 6;
   localparam int EQ_MAX        = 5;
   localparam int IRQ_LOS       = 0;
   localparam int IRQ_FRAME     = 1;
   localparam int IRQ_OVF       = 2;
   localparam int IRQ_UNF       = 3;
   localparam int IRQ_N         = 4;
   localparam int STAT_CNT_LO   = 8;
   localparam int STAT_EMPTY    = 16;
   localparam int STAT_FULL     = 17;

   // ------------------------------------------------------------
   // reset values and sizes
   // ------------------------------------------------------------
   localparam logic [7:0]  ACCESS_RST     = 8'h00;
   localparam logic [7:0]  JITTER_RST     = 8'h00;
   localparam logic [7:0]  EQUAL_RST      = 8'h00;
   localparam logic [3:0]  IRQ_RST        = 4'h0;
   localparam logic [7:0]  DEPTH_STEP     = 8'h10;
   localparam int          FIFO_WORDS     = 128;
   localparam logic [14:0] PRBS_SEED      = 15'h7fff;
   localparam logic [1:0]  RESP_OKAY      = 2'b00;
   localparam logic [1:0]  RESP_SLVERR    = 2'b10;

   // a-law digital milliwatt, eight byte cycle
   localparam logic [63:0] MW_TABLE       = 64'h34_21_21_34_b4_a1_a1_b4;

   // ------------------------------------------------------------
   // modes and carriers
   // ------------------------------------------------------------
   typedef enum logic [1:0] {EQ_AUTO, EQ_ONE_STAGE, EQ_TWO_STAGE, EQ_FLAT} ajc_eq_mode_t;

   typedef struct packed {
      logic       on_transmit;
      logic       on_receive;
      logic [7:0] depth_words;
      logic       centring;
      logic       out_bit;
   } ajc_ja_out_t;

   typedef struct packed {
      logic [7:0] fill;
      logic       empty;
      logic       full;
   } ajc_ja_stat_t;

endpackage

// ==== hdl/ajc_top.sv ====
// access, jitter attenuator and equalizer control bank behind an axi4-lite slave
//
// Functional notes
// - select one: loss pin high only while line signal loss holds
// - select zero: loss pin high on signal loss or lost frame lock
// - sequence bit one: flagged slots carry a-law digital milliwatt
// - sequence bit zero: flagged slots carry prbs 2^15-1
// - writing sequence bit as one restarts the prbs generator
// - frame pulse format bit picks alternate or native frame pulse on pin
// - enable bit zero disables attenuator; one inserts it on chosen side
// - side bit one acts on transmit data, zero on receive data
// - centre toggle moves read pointer to the fifo centre
// - depth code 0..7 gives 16..128 words in steps of 16
// - clear bit resets attenuator pointers and status to empty
// - clear leaves stored fifo data untouched
// - auto-disable zero runs equalizer automatic, one turns auto off
// - auto off with mid bit: one-stage equalization, about 6 dB
// - auto off, mid zero, max one: two-stage equalization, about 12 dB
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/10ps

module ajc_top
   import ajc_pkg::*;
(
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // axi4-lite write
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // line status from the framer
   input  wire logic              line_signal_absent_flag,
   input  wire logic              frame_locked,
   output logic                   signal_loss_output_pin,
   // per-slot test sequences
   input  wire logic              slot_byte_tick,
   input  wire logic              per_slot_transmit_test,
   input  wire logic              per_slot_receive_test,
   output logic [7:0]             test_byte,
   output logic                   test_byte_valid,
   // backplane frame pulse
   output logic                   frame_pulse_format,
   // jitter attenuator data path
   input  wire logic              ja_in_valid,
   input  wire logic              ja_in_bit,
   input  wire logic              ja_out_req,
   output ajc_ja_out_t            ja_out,
   // receive equalizer
   output ajc_eq_mode_t           eq_mode,
   // interrupt
   output logic                   irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic                  aw_have;
      logic [ADDR_W-1:0]     aw_addr;
      logic                  w_have;
      logic [31:0]           w_data;
      logic                  w_lane0;
      logic                  awready;
      logic                  wready;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  arready;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
      logic [7:0]            access_ctrl;
      logic [7:0]            jitter_ctrl;
      logic [7:0]            equal_ctrl;
      logic [IRQ_N-1:0]      irq_status;
      logic [IRQ_N-1:0]      irq_mask;
      logic                  irq;
      logic                  los_prev;
      logic                  frame_lost_prev;
      logic                  alarm_pin;
      logic [14:0]           lfsr;
      logic [2:0]            mw_idx;
      logic [7:0]            test_byte;
      logic                  test_valid;
      logic [FIFO_WORDS-1:0] mem;
      logic [6:0]            wr_ptr;
      logic [6:0]            rd_ptr;
      logic [7:0]            fill;
      ajc_ja_out_t           ja;
      ajc_eq_mode_t          eq;
   } ajc_state_t;

   ajc_state_t st_reg;
   ajc_state_t st_next;

   // assertions below sample on the rising clock and rest during reset
   default clocking ajc_cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // word index of a byte address, or all ones when misaligned
   function automatic logic [7:0] word_index(input logic [ADDR_W-1:0] a);
      word_index = (a[1:0] == 2'b00) ? a[ADDR_W-1:2] : 8'hff;
   endfunction

   function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      i = word_index(a);
      is_mapped = (i == IDX_ACCESS) || (i == IDX_JITTER) || (i == IDX_EQUAL)
                  || (i == IDX_IRQ_STATUS) || (i == IDX_IRQ_MASK);
   endfunction

   // eight steps of x^15 + x^14 + 1
   function automatic logic [22:0] prbs_step8(input logic [14:0] l);
      logic [14:0] v;
      logic [7:0]  b;
      logic        fb;
      v = l;
      b = 8'h00;
      for (int k = 0; k < 8; k++) begin
         fb = v[14] ^ v[13];
         v  = {v[13:0], fb};
         b  = {b[6:0], fb};
      end
      prbs_step8 = {v, b};
   endfunction

   ajc_ja_stat_t ja_stat;
   assign ja_stat.fill  = st_reg.fill;
   assign ja_stat.empty = (st_reg.fill == 8'h00);
   assign ja_stat.full  = (st_reg.fill == st_reg.ja.depth_words);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      logic        do_write;
      logic [7:0]  widx;
      logic [7:0]  ridx;
      logic [7:0]  wbyte;
      logic        centre_req;
      logic        prbs_restart;
      logic [7:0]  depth;
      logic [22:0] step;
      logic        flagged;
      logic        frame_lost;
      logic [IRQ_N-1:0] ev;
      logic        push;
      logic        pop;
      do_write     = 1'b0;
      widx         = word_index(st_reg.aw_addr);
      ridx         = word_index(s_axi_araddr);
      wbyte        = st_reg.w_data[7:0];
      centre_req   = 1'b0;
      prbs_restart = 1'b0;
      step         = 23'h0;
      depth        = 8'h00;
      flagged      = per_slot_transmit_test | per_slot_receive_test;
      frame_lost   = ~frame_locked;
      ev           = '0;
      push         = 1'b0;
      pop          = 1'b0;
      st_next      = st_reg;

      // write channel capture, either order
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.w_have  = 1'b1;
         st_next.w_data  = s_axi_wdata;
         st_next.w_lane0 = s_axi_wstrb[0];
      end
      if (st_reg.bvalid && s_axi_bready)
         st_next.bvalid = 1'b0;
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         do_write        = is_mapped(st_reg.aw_addr) && st_reg.w_lane0;
         st_next.aw_have = 1'b0;
         st_next.w_have  = 1'b0;
         st_next.bvalid  = 1'b1;
         st_next.bresp   = is_mapped(st_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end

      // register write effects
      if (do_write) begin
         case (widx)
            IDX_ACCESS: begin
               st_next.access_ctrl = {5'h00, wbyte[2:0]};
               prbs_restart        = wbyte[ACC_SEQ];
            end
            IDX_JITTER: begin
               st_next.jitter_ctrl = {wbyte[7:1], 1'b0};
               centre_req          = wbyte[JA_CENTRE] ^ st_reg.jitter_ctrl[JA_CENTRE];
            end
            IDX_EQUAL:      st_next.equal_ctrl = {wbyte[7:5], 5'h00};
            IDX_IRQ_STATUS: st_next.irq_status = st_reg.irq_status & ~wbyte[IRQ_N-1:0];
            IDX_IRQ_MASK:   st_next.irq_mask   = wbyte[IRQ_N-1:0];
            default: ;
         endcase
      end
      st_next.awready = !st_next.aw_have && !st_next.bvalid;
      st_next.wready  = !st_next.w_have && !st_next.bvalid;

      // read channel, answer one cycle after the address is taken
      if (st_reg.rvalid && s_axi_rready)
         st_next.rvalid = 1'b0;
      if (s_axi_arvalid && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (ridx)
            IDX_ACCESS:     st_next.rdata = {24'h0, st_reg.access_ctrl};
            IDX_JITTER:     st_next.rdata = {24'h0, st_reg.jitter_ctrl};
            IDX_EQUAL:      st_next.rdata = {24'h0, st_reg.equal_ctrl};
            IDX_IRQ_STATUS: st_next.rdata = {14'h0, ja_stat.full, ja_stat.empty, ja_stat.fill,
                                             4'h0, st_reg.irq_status};
            IDX_IRQ_MASK:   st_next.rdata = {28'h0, st_reg.irq_mask};
            default:        st_next.rdata = 32'h0;
         endcase
      end
      st_next.arready = !st_next.rvalid;

      // loss alarm pin source
      if (st_reg.access_ctrl[ACC_ALARM_SEL])
         st_next.alarm_pin = line_signal_absent_flag;
      else
         st_next.alarm_pin = line_signal_absent_flag | frame_lost;
      st_next.los_prev        = line_signal_absent_flag;
      st_next.frame_lost_prev = frame_lost;
      ev[IRQ_LOS]             = line_signal_absent_flag & ~st_reg.los_prev;
      ev[IRQ_FRAME]           = frame_lost & ~st_reg.frame_lost_prev;

      // per-slot test sequence source
      st_next.test_valid = slot_byte_tick & flagged;
      step = prbs_step8(st_reg.lfsr);
      if (prbs_restart) begin
         st_next.lfsr = PRBS_SEED;
      end else if (slot_byte_tick && flagged) begin
         if (st_reg.access_ctrl[ACC_SEQ]) begin
            st_next.test_byte = MW_TABLE[63 - 8 * st_reg.mw_idx -: 8];
            st_next.mw_idx    = st_reg.mw_idx + 3'd1;
         end else begin
            st_next.test_byte = step[7:0];
            st_next.lfsr      = step[22:8];
         end
      end

      // attenuator control decode, centring strobe lasts one cycle
      st_next.ja.centring = 1'b0;
      depth = {1'b0, st_reg.jitter_ctrl[JA_DEPTH_LO+:3], 4'h0} + DEPTH_STEP;
      st_next.ja.depth_words = depth;
      st_next.ja.on_transmit = st_reg.jitter_ctrl[JA_ENABLE] & st_reg.jitter_ctrl[JA_SIDE];
      st_next.ja.on_receive  = st_reg.jitter_ctrl[JA_ENABLE] & ~st_reg.jitter_ctrl[JA_SIDE];

      // jitter attenuator fifo
      if (st_reg.jitter_ctrl[JA_CLEAR]) begin
         // pointers and fill only; stored bits stay
         st_next.wr_ptr = 7'h00;
         st_next.rd_ptr = 7'h00;
         st_next.fill   = 8'h00;
      end else if (centre_req) begin
         st_next.rd_ptr      = st_reg.wr_ptr - depth[7:1];
         st_next.fill        = {1'b0, depth[7:1]};
         st_next.ja.centring = 1'b1;
      end else if (st_reg.jitter_ctrl[JA_ENABLE]) begin
         push = ja_in_valid && (st_reg.fill != depth);
         pop  = ja_out_req && (st_reg.fill != 8'h00);
         ev[IRQ_OVF] = ja_in_valid && (st_reg.fill >= depth) && !pop;
         ev[IRQ_UNF] = ja_out_req && (st_reg.fill == 8'h00);
         if (push) begin
            st_next.mem[st_reg.wr_ptr] = ja_in_bit;
            st_next.wr_ptr             = st_reg.wr_ptr + 7'd1;
         end
         if (pop) begin
            st_next.ja.out_bit = st_reg.mem[st_reg.rd_ptr];
            st_next.rd_ptr     = st_reg.rd_ptr + 7'd1;
         end
         st_next.fill = st_reg.fill + {7'h0, push} - {7'h0, pop};
      end else if (ja_in_valid) begin
         st_next.ja.out_bit = ja_in_bit; // bypass
      end

      // receive equalizer mode
      if (!st_reg.equal_ctrl[EQ_DISABLE])
         st_next.eq = EQ_AUTO;
      else if (st_reg.equal_ctrl[EQ_MID])
         st_next.eq = EQ_ONE_STAGE;
      else if (st_reg.equal_ctrl[EQ_MAX])
         st_next.eq = EQ_TWO_STAGE;
      else
         st_next.eq = EQ_FLAT;

      // sticky status, set wins over the clear
      st_next.irq_status = st_next.irq_status | ev;
      st_next.irq        = |(st_next.irq_status & st_next.irq_mask);
   end

   // ------------------------------------------------------------
   // state register, synchronous active-low reset
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg                <= '0;
         st_reg.access_ctrl    <= ACCESS_RST;
         st_reg.jitter_ctrl    <= JITTER_RST;
         st_reg.equal_ctrl     <= EQUAL_RST;
         st_reg.irq_status     <= IRQ_RST;
         st_reg.irq_mask       <= IRQ_RST;
         st_reg.lfsr           <= PRBS_SEED;
         st_reg.ja.depth_words <= DEPTH_STEP;
      end else begin
         st_reg <= st_next;
      end
   end

   // ------------------------------------------------------------
   // outputs, each straight from the state register
   // ------------------------------------------------------------
   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready = st_reg.wready;
   assign s_axi_bvalid = st_reg.bvalid;
   assign s_axi_bresp = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid = st_reg.rvalid;
   assign s_axi_rdata = st_reg.rdata;
   assign s_axi_rresp = st_reg.rresp;
   assign signal_loss_output_pin = st_reg.alarm_pin;
   assign test_byte = st_reg.test_byte;
   assign test_byte_valid = st_reg.test_valid;
   assign frame_pulse_format = st_reg.access_ctrl[ACC_FP_FMT];
   assign ja_out = st_reg.ja;
   assign eq_mode = st_reg.eq;
   assign irq = st_reg.irq;

   // ------------------------------------------------------------
   // assertions and covers
   // ------------------------------------------------------------
   a_loss_pin_source: assert property (signal_loss_output_pin ==
      $past(line_signal_absent_flag | (~frame_locked & ~st_reg.access_ctrl[ACC_ALARM_SEL])))
      else $error("loss pin does not follow its source");
   a_eq_auto_mode: assert property (!st_reg.equal_ctrl[EQ_DISABLE] |=> eq_mode == EQ_AUTO)
      else $error("equalizer left automatic mode");
   a_eq_one_stage: assert property (st_reg.equal_ctrl[EQ_DISABLE:EQ_MID] == 2'b11 |=> eq_mode == EQ_ONE_STAGE)
      else $error("one-stage equalization not chosen");
   a_eq_two_stage: assert property (st_reg.equal_ctrl[EQ_DISABLE:EQ_MAX] == 3'b101 |=> eq_mode == EQ_TWO_STAGE)
      else $error("two-stage equalization not chosen");
   a_ja_disabled: assert property (!st_reg.jitter_ctrl[JA_ENABLE] |=> !ja_out.on_transmit && !ja_out.on_receive)
      else $error("attenuator active while disabled");
   a_clear_empties: assert property (st_reg.jitter_ctrl[JA_CLEAR] |=> st_reg.fill == 8'h00)
      else $error("attenuator not empty after clear");
   a_centre_single: assert property (ja_out.centring |=> !ja_out.centring)
      else $error("centering lasted more than one cycle");
   c_centring: cover property (ja_out.centring);
   c_eq_two_stage: cover property (eq_mode == EQ_TWO_STAGE);
   c_irq_raised: cover property (irq);

endmodule

// ==== verif/ajc_host_model.sv ====
// host-side axi4-lite master that issues register cycles to the bank
`timescale 1ns/10ps
module ajc_host_model
   import ajc_pkg::*;
(
   // clock
   input  wire logic              aclk,
   // write channels
   output logic [ADDR_W-1:0]      s_axi_awaddr,
   output logic                   s_axi_awvalid,
   input  wire logic              s_axi_awready,
   output logic [31:0]            s_axi_wdata,
   output logic [3:0]             s_axi_wstrb,
   output logic                   s_axi_wvalid,
   input  wire logic              s_axi_wready,
   input  wire logic [1:0]        s_axi_bresp,
   input  wire logic              s_axi_bvalid,
   output logic                   s_axi_bready,
   // read channels
   output logic [ADDR_W-1:0]      s_axi_araddr,
   output logic                   s_axi_arvalid,
   input  wire logic              s_axi_arready,
   input  wire logic [31:0]       s_axi_rdata,
   input  wire logic [1:0]        s_axi_rresp,
   input  wire logic              s_axi_rvalid,
   output logic                   s_axi_rready
);
   logic hung = 1'b0;
   // idle levels at time zero
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
   end
   // write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] idx, input logic [31:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_awaddr  <= {idx, 2'b00};
      s_axi_wdata   <= v;
      s_axi_wstrb   <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 200);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      hung = hung | !s_axi_bvalid;
   endtask
   // read: rready held until the answer is sampled
   task automatic rd(input logic [7:0] idx, output logic [31:0] v, output logic [1:0] resp);
      int n;
      n = 0;
      @(posedge aclk);
      s_axi_araddr  <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 200);
      v = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      hung = hung | !s_axi_rvalid;
   endtask
endmodule

// ==== verif/ajc_top_tb.sv ====
// self-checking bench for the access, jitter and equalizer control bank
`timescale 1ns/10ps
module ajc_top_tb;
   import ajc_pkg::*;
   // stimulus, bus wires and bank outputs
   logic aclk, aresetn, line_signal_absent_flag, frame_locked, slot_byte_tick, per_slot_transmit_test;
   logic per_slot_receive_test, ja_in_valid, ja_in_bit, ja_out_req, cprev;
   logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d, a, j, e, seed = 32'h0000_22ab;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, signal_loss_output_pin;
   logic [7:0] test_byte, q1[$], q2[$];
   logic test_byte_valid, frame_pulse_format, irq;
   ajc_ja_out_t ja_out;
   ajc_eq_mode_t eq_mode;
   int num_errors = 0, checked = 0, rises = 0, i, k;
   ajc_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_signal_absent_flag,
      .frame_locked, .signal_loss_output_pin, .slot_byte_tick, .per_slot_transmit_test, .per_slot_receive_test,
      .test_byte, .test_byte_valid, .frame_pulse_format, .ja_in_valid, .ja_in_bit, .ja_out_req, .ja_out,
      .eq_mode, .irq);
   ajc_host_model host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   // clock and centring pulse counter
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      if (ja_out.centring === 1'b1 && cprev !== 1'b1) rises++;
      cprev <= ja_out.centring;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // register cycles with response and data comparison
   task automatic wr(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] er = RESP_OKAY);
      host.wr(idx, v, r);
      chk({30'h0, r}, {30'h0, er}, "write response");
      if (host.hung) begin
         chk(0, 1, "bus timeout");
         complete_run();
      end
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] ev,
                     input logic [1:0] er = RESP_OKAY);
      host.rd(idx, d, r);
      chk({30'h0, r}, {30'h0, er}, "read response");
      chk(d & m, ev & m, "read data");
      if (host.hung) begin
         chk(0, 1, "bus timeout");
         complete_run();
      end
   endtask
   // collect four flagged slot bytes
   task automatic grab(ref logic [7:0] q[$]);
      int n;
      q.delete();
      for (int b = 0; b < 4; b++) begin
         slot_byte_tick <= 1'b1;
         n = 0;
         do begin
            @(posedge aclk);
            if (n == 0) slot_byte_tick <= 1'b0;
            n++;
         end while (test_byte_valid !== 1'b1 && n < 20);
         if (test_byte_valid !== 1'b1) begin
            chk(0, 1, "slot byte timeout");
            complete_run();
         end
         q.push_back(test_byte);
      end
   endtask
   // run limit
   initial begin
      repeat (90000) @(posedge aclk);
      num_errors++;
      $display("unexpected at %0t: run limit reached", $time);
      complete_run();
   end
   // main sequence
   initial begin
      {aresetn, line_signal_absent_flag, slot_byte_tick, per_slot_receive_test} = 4'h0;
      {ja_in_valid, ja_in_bit, ja_out_req, frame_locked, per_slot_transmit_test} = 5'h03;
      tick(12);
      aresetn <= 1'b1;
      tick(2);
      rd(IDX_ACCESS, 32'h07, ACCESS_RST);
      rd(IDX_JITTER, 32'hfe, JITTER_RST);
      rd(IDX_EQUAL, 32'he0, EQUAL_RST);
      rd(IDX_IRQ_MASK, 32'h0f, IRQ_RST);
      rd(8'h05, 32'h0, 32'h0, RESP_SLVERR);
      wr(8'h05, 32'h5a, RESP_SLVERR);
      $display("test reset and map done");
      for (i = 0; i < 16; i++) begin
         a = xs() & 32'h07;
         j = (xs() & 32'he0) | ((i % 8) << 2);
         e = xs() & 32'he0;
         wr(IDX_ACCESS, a);
         wr(IDX_JITTER, j);
         wr(IDX_EQUAL, e);
         tick(4);
         chk(frame_pulse_format, a[0], "frame pulse format");
         chk(ja_out.on_transmit, j[7] & j[6], "attenuator on transmit");
         chk(ja_out.on_receive, j[7] & !j[6], "attenuator on receive");
         chk(ja_out.depth_words, ((i % 8) + 1) * 16, "fifo depth");
         chk(eq_mode, !e[7] ? EQ_AUTO : e[6] ? EQ_ONE_STAGE : e[5] ? EQ_TWO_STAGE : EQ_FLAT, "eq mode");
         rd(IDX_ACCESS, 32'h07, a);
         rd(IDX_JITTER, 32'hfe, j);
         rd(IDX_EQUAL, 32'he0, e);
      end
      $display("test register fields done");
      for (k = 0; k < 8; k++) begin
         wr(IDX_ACCESS, {29'h0, k[2], 2'b00});
         line_signal_absent_flag <= k[0];
         frame_locked <= !k[1];
         tick(4);
         chk(signal_loss_output_pin, k[2] ? k[0] : k[0] | k[1], "loss pin");
      end
      line_signal_absent_flag <= 1'b0;
      frame_locked <= 1'b1;
      $display("test loss pin done");
      wr(IDX_IRQ_MASK, 32'h0);
      wr(IDX_IRQ_STATUS, 32'h0f);
      rd(IDX_IRQ_STATUS, 32'h01, 32'h0);
      line_signal_absent_flag <= 1'b1;
      tick(4);
      line_signal_absent_flag <= 1'b0;
      rd(IDX_IRQ_STATUS, 32'h01, 32'h01);
      chk(irq, 1'b0, "irq masked");
      wr(IDX_IRQ_MASK, 32'h01);
      tick(2);
      chk(irq, 1'b1, "irq raised");
      wr(IDX_IRQ_STATUS, 32'h01);
      tick(2);
      rd(IDX_IRQ_STATUS, 32'h01, 32'h0);
      chk(irq, 1'b0, "irq cleared");
      $display("test interrupt done");
      wr(IDX_ACCESS, 32'h02);
      grab(q1);
      foreach (q1[b]) chk(q1[b], MW_TABLE[63 - 8 * b -: 8], "milliwatt byte");
      for (k = 0; k < 2; k++) begin
         wr(IDX_ACCESS, 32'h02);
         wr(IDX_ACCESS, 32'h00);
         if (k == 0) grab(q1);
         else grab(q2);
      end
      foreach (q1[b]) chk(q2[b], q1[b], "sequence after restart");
      $display("test slot sequences done");
      wr(IDX_JITTER, 32'h82);
      wr(IDX_JITTER, 32'h80);
      ja_in_valid <= 1'b1;
      for (k = 0; k < 8; k++) begin
         d = xs();
         ja_in_bit <= d[0];
         if (k == 0) a = d;
         @(posedge aclk);
      end
      ja_in_valid <= 1'b0;
      rd(IDX_IRQ_STATUS, 32'h1_ff00, 32'h0800);
      ja_out_req <= 1'b1;
      @(posedge aclk);
      ja_out_req <= 1'b0;
      tick(2);
      chk(ja_out.out_bit, a[0], "first bit through fifo");
      wr(IDX_JITTER, 32'h82);
      tick(2);
      rd(IDX_IRQ_STATUS, 32'h1_ff00, 32'h1_0000);
      wr(IDX_JITTER, 32'h80);
      rises = 0;
      wr(IDX_JITTER, 32'ha0);
      tick(30);
      chk(rises, 1, "one centring per toggle");
      rises = 0;
      wr(IDX_JITTER, 32'ha0);
      tick(30);
      chk(rises, 0, "no centring without change");
      $display("test attenuator done");
      complete_run();
   end
endmodule
